// File: include/scg_pkg.sv
// Purpose: Constants for the sleep-mode unit clock gating block
// Assumes: 32-bit register bus, 12-bit byte address
// Notes: Unit index 0..7 ports A..H, 8 MAC, 9 PHY
package scg_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_UNITS = 10;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_RUN_CFG = 12'h060;
    localparam logic [11:0] OFF_RUN_GATE = 12'h108;
    localparam logic [11:0] OFF_SLEEP_GATE = 12'h118;
    localparam logic [11:0] OFF_DEEP_GATE = 12'h128;
    localparam logic [11:0] OFF_INT_STAT = 12'h200;
    localparam logic [11:0] OFF_INT_CLR = 12'h204;
    localparam logic [11:0] OFF_INT_EN = 12'h208;
    localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int BIT_MAC = 28;
    localparam int BIT_PHY = 30;
    localparam int BIT_AUTO_GATE = 27;
    localparam logic [31:0] GATE_MASK = 32'h5000_00ff;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b10
    } scg_mode_e;
endpackage : scg_pkg

// File: include/scg_unit_if.sv
// Purpose: Carries unit enables, accesses and faults between modules
// Assumes: All signals on the one system clock
// Notes: ctrl drives enables and accesses, chk answers faults
interface scg_unit_if #(parameter int N = 10);
    logic [N-1:0] gate_en;
    logic [N-1:0] acc;
    logic [N-1:0] fault;
    modport ctrl (output gate_en, output acc, input fault);
    modport chk (input gate_en, input acc, output fault);
endinterface : scg_unit_if

// File: rtl/scg_fault_chk.sv
// Purpose: Per-unit bus fault on access to an unclocked unit
// Assumes: Accesses are one-cycle strobes on the system clock
// Notes: Fault pulses one cycle after the access
module scg_fault_chk #(
    parameter int N = 10
) (
    input wire logic clk,
    input wire logic rst,
    scg_unit_if.chk u
);
    // ------------------------------------------------------------
    // Fault per unit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_unit
            always_ff @(posedge clk)
            begin
                if (rst)
                    u.fault[i] <= 1'b0;
                else
                    u.fault[i] <= u.acc[i] & ~u.gate_en[i];
            end
        end
    endgenerate

    // chk_fault_gated
    chk_fault_gated: assert property (@(posedge clk) disable iff (rst)
        (u.acc[0] && !u.gate_en[0]) |=> u.fault[0])
        else $error("Access to gated unit gave no fault");
    // chk_no_fault_open
    chk_no_fault_open: assert property (@(posedge clk) disable iff (rst)
        (u.gate_en[0] || !u.acc[0]) |=> !u.fault[0])
        else $error("Fault on clocked unit");
endmodule : scg_fault_chk

// File: rtl/scg_gate_ctrl.sv
// Purpose: Run, sleep and deep-sleep unit clock gating registers
// Assumes: Mode inputs and unit accesses are on REF_CLK
// Notes: Faults on gated units set sticky interrupt status bits
//
// Notes on behaviour
// - Sleep gate bits 7..0 enable ports H..A and bit 30 the PHY.
// - A set bit clocks its unit, a clear bit leaves it unclocked.
// - Any access to an unclocked unit is answered with a bus fault.
// - All gate bits clear on reset, the register reads zero.
// - The sleep gate register sits at offset 0x118 from the base.
// - Run uses its own gate register; sleep and deep-sleep use theirs only while auto gating is enabled, else the run register.
// - Sleep values apply only while auto gating is enabled.
// - Reserved bits read zero and ignore writes.
// - Bit 28 is the read-write gate for the MAC, reset to zero.
module scg_gate_ctrl #(
    parameter int N = scg_pkg::NUM_UNITS
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic SLEEP_MODE,
    input wire logic DEEP_SLEEP_MODE,
    input wire logic [9:0] UNIT_ACC,
    output logic [9:0] UNIT_CLK_EN,
    output logic [9:0] UNIT_FAULT,
    output logic IRQ
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (N != 10)
    begin : g_bad_n
        $error("Unit count must be 10");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] run_unit_clock_gate;
    logic [31:0] sleep_unit_clock_gate;
    logic [31:0] deep_sleep_unit_clock_gate;
    logic [31:0] run_clock_config;
    logic [9:0] int_stat;
    logic [9:0] int_en;
    logic [9:0] next_gate;
    scg_pkg::scg_mode_e mode;
    logic auto_gate_enable;
    logic wr_run;
    logic wr_sleep;
    logic wr_deep;
    logic wr_cfg;
    logic wr_clr;
    logic wr_en;
    logic [9:0] clr_bits;

    scg_unit_if #(.N(10)) unit_bus ();

    // Pack a gate word into the compact unit vector
    function automatic logic [9:0] to_units(input logic [31:0] w);
        to_units = {w[scg_pkg::BIT_PHY], w[scg_pkg::BIT_MAC], w[7:0]};
    endfunction : to_units

    // Spread a compact unit vector into the gate word layout
    function automatic logic [31:0] to_word(input logic [9:0] u);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[7:0] = u[7:0];
        w[scg_pkg::BIT_MAC] = u[8];
        w[scg_pkg::BIT_PHY] = u[9];
        to_word = w;
    endfunction : to_word

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign wr_run = REG_WR && (REG_ADDR == scg_pkg::OFF_RUN_GATE);
    assign wr_sleep = REG_WR && (REG_ADDR == scg_pkg::OFF_SLEEP_GATE);
    assign wr_deep = REG_WR && (REG_ADDR == scg_pkg::OFF_DEEP_GATE);
    assign wr_cfg = REG_WR && (REG_ADDR == scg_pkg::OFF_RUN_CFG);
    assign wr_clr = REG_WR && (REG_ADDR == scg_pkg::OFF_INT_CLR);
    assign wr_en = REG_WR && (REG_ADDR == scg_pkg::OFF_INT_EN);
    assign clr_bits = wr_clr ? to_units(REG_WDATA) : 10'h000;
    assign auto_gate_enable = run_clock_config[scg_pkg::BIT_AUTO_GATE];

    // ------------------------------------------------------------
    // Gate registers
    // ------------------------------------------------------------
    // clear on reset
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            run_unit_clock_gate <= scg_pkg::GATE_RESET;
        else if (wr_run)
            run_unit_clock_gate <= REG_WDATA & scg_pkg::GATE_MASK;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            sleep_unit_clock_gate <= scg_pkg::GATE_RESET;
        else if (wr_sleep)
            sleep_unit_clock_gate <= REG_WDATA & scg_pkg::GATE_MASK;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            deep_sleep_unit_clock_gate <= scg_pkg::GATE_RESET;
        else if (wr_deep)
            deep_sleep_unit_clock_gate <= REG_WDATA & scg_pkg::GATE_MASK;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            run_clock_config <= scg_pkg::CFG_RESET;
        else if (wr_cfg)
            run_clock_config[scg_pkg::BIT_AUTO_GATE] <=
                REG_WDATA[scg_pkg::BIT_AUTO_GATE];
    end

    // ------------------------------------------------------------
    // Mode and gate selection
    // ------------------------------------------------------------
    always_comb
    begin
        if (DEEP_SLEEP_MODE)
            mode = scg_pkg::MODE_DEEP;
        else if (SLEEP_MODE)
            mode = scg_pkg::MODE_SLEEP;
        else
            mode = scg_pkg::MODE_RUN;
    end

    // one register per mode, sleep and deep sleep need auto gating
    always_comb
    begin
        case (mode)
            scg_pkg::MODE_SLEEP:
                next_gate = auto_gate_enable
                    ? to_units(sleep_unit_clock_gate)
                    : to_units(run_unit_clock_gate);
            scg_pkg::MODE_DEEP:
                next_gate = auto_gate_enable
                    ? to_units(deep_sleep_unit_clock_gate)
                    : to_units(run_unit_clock_gate);
            default:
                next_gate = to_units(run_unit_clock_gate);
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            UNIT_CLK_EN <= 10'h000;
        else
            UNIT_CLK_EN <= next_gate;
    end

    // ------------------------------------------------------------
    // Fault checking
    // ------------------------------------------------------------
    assign unit_bus.gate_en = UNIT_CLK_EN;
    assign unit_bus.acc = UNIT_ACC;
    assign UNIT_FAULT = unit_bus.fault;

    scg_fault_chk #(.N(10)) u_fault (
        .clk(REF_CLK),
        .rst(RESET),
        .u(unit_bus.chk)
    );

    // ------------------------------------------------------------
    // Interrupt status and enable
    // ------------------------------------------------------------
    // fault events are sticky, set wins over clear
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            int_stat <= 10'h000;
        else
            int_stat <= (int_stat & ~clr_bits) | UNIT_FAULT;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            int_en <= 10'h000;
        else if (wr_en)
            int_en <= to_units(REG_WDATA);
    end

    assign IRQ = |(int_stat & int_en);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // reserved and unmapped read zero
    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
            REG_RDATA <= 32'h0000_0000;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                scg_pkg::OFF_RUN_GATE:
                    REG_RDATA <= run_unit_clock_gate;
                scg_pkg::OFF_SLEEP_GATE:
                    REG_RDATA <= sleep_unit_clock_gate;
                scg_pkg::OFF_DEEP_GATE:
                    REG_RDATA <= deep_sleep_unit_clock_gate;
                scg_pkg::OFF_RUN_CFG:
                    REG_RDATA <= run_clock_config;
                scg_pkg::OFF_INT_STAT:
                    REG_RDATA <= to_word(int_stat);
                scg_pkg::OFF_INT_EN:
                    REG_RDATA <= to_word(int_en);
                default:
                    REG_RDATA <= 32'h0000_0000;
            endcase
        end
        else
            REG_RDATA <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_reset_clears: assert property (@(posedge REF_CLK)
        RESET |=> (sleep_unit_clock_gate == 32'h0000_0000)
            && (UNIT_CLK_EN == 10'h000))
        else $error("Gate state not cleared by reset");

    chk_sleep_write: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        wr_sleep |=>
            sleep_unit_clock_gate == ($past(REG_WDATA) & 32'h5000_00ff))
        else $error("Sleep gate write not stored");

    chk_reserved_zero: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (sleep_unit_clock_gate & 32'hafff_ff00) == 32'h0000_0000)
        else $error("Reserved sleep gate bit set");

    chk_readback: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (REG_RD && REG_ADDR == 12'h118 && !REG_WR)
            |=> REG_RDATA == $past(sleep_unit_clock_gate))
        else $error("Sleep gate readback wrong");

    chk_mac_bit: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (SLEEP_MODE && !DEEP_SLEEP_MODE && auto_gate_enable)
            |=> UNIT_CLK_EN[8] == $past(sleep_unit_clock_gate[28]))
        else $error("MAC enable does not follow sleep bit 28");

    chk_sleep_select: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (SLEEP_MODE && !DEEP_SLEEP_MODE && auto_gate_enable)
            |=> UNIT_CLK_EN == to_units($past(sleep_unit_clock_gate)))
        else $error("Sleep gate not applied in sleep");

    chk_sleep_no_auto: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (SLEEP_MODE && !auto_gate_enable)
            |=> UNIT_CLK_EN == to_units($past(run_unit_clock_gate)))
        else $error("Run gate not kept without auto gating");

    chk_mode_regs: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (!SLEEP_MODE && !DEEP_SLEEP_MODE)
            |=> UNIT_CLK_EN == to_units($past(run_unit_clock_gate)))
        else $error("Run gate not applied while running");

    chk_unit_enable: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        (DEEP_SLEEP_MODE && auto_gate_enable)
            |=> UNIT_CLK_EN == to_units($past(deep_sleep_unit_clock_gate)))
        else $error("Deep gate not applied in deep sleep");

    chk_fault_sticky: assert property (@(posedge REF_CLK)
        disable iff (RESET)
        UNIT_FAULT[0] |=> int_stat[0]
            ##1 (int_stat[0] || $past(clr_bits[0])))
        else $error("Fault status not sticky");

    cov_sleep_gated: cover property (@(posedge REF_CLK)
        disable iff (RESET) SLEEP_MODE && auto_gate_enable
            && |UNIT_CLK_EN);
    cov_fault_irq: cover property (@(posedge REF_CLK)
        disable iff (RESET) |UNIT_FAULT ##1 IRQ);
    cov_set_clear: cover property (@(posedge REF_CLK)
        disable iff (RESET) |(clr_bits & UNIT_FAULT));
endmodule : scg_gate_ctrl

// File: verification/sleep_mode_port_clock_gating_tb.sv
// Purpose: Self-checking bench for the sleep unit clock gating block
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Unit vector bits 7:0 ports A..H, 8 MAC, 9 PHY
module sleep_mode_port_clock_gating_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [11:0] REG_ADDR = 12'h000;
    logic [31:0] REG_WDATA = 32'h0000_0000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic SLEEP_MODE = 1'b0;
    logic DEEP_SLEEP_MODE = 1'b0;
    logic [9:0] UNIT_ACC = 10'h000;
    logic [9:0] UNIT_CLK_EN;
    logic [9:0] UNIT_FAULT;
    logic IRQ;
    int errors = 0;
    int n_tests = 0;
    int pos;

    always #5 REF_CLK = ~REF_CLK;

    scg_gate_ctrl i_dut (.REF_CLK(REF_CLK), .RESET(RESET),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SLEEP_MODE(SLEEP_MODE),
        .DEEP_SLEEP_MODE(DEEP_SLEEP_MODE), .UNIT_ACC(UNIT_ACC),
        .UNIT_CLK_EN(UNIT_CLK_EN), .UNIT_FAULT(UNIT_FAULT), .IRQ(IRQ));

    // ------------------------------------------------------------
    // Compare and access tasks
    // ------------------------------------------------------------
    task automatic chk32(input string w, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask : chk32
    task automatic chk10(input string w, input logic [9:0] e);
        n_tests++;
        if (UNIT_CLK_EN !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", w, e, UNIT_CLK_EN);
        end
    endtask : chk10
    task automatic chk1(input logic e);
        n_tests++;
        if (IRQ !== e)
        begin
            errors++;
            $display("[ERR] irq expected %b seen %b", e, IRQ);
        end
    endtask : chk1
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge REF_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        chk32($sformatf("read %h", a), e, REG_RDATA);
    endtask : rd
    task automatic acc(input logic [9:0] m, input logic [9:0] e);
        @(posedge REF_CLK);
        UNIT_ACC <= m;
        @(posedge REF_CLK);
        UNIT_ACC <= 10'h000;
        #1;
        chk32("unit fault", {22'h0, e}, {22'h0, UNIT_FAULT});
    endtask : acc
    task automatic settle(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask : settle
    task automatic set_mode(input logic s, input logic d);
        @(posedge REF_CLK);
        SLEEP_MODE <= s;
        DEEP_SLEEP_MODE <= d;
    endtask : set_mode
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge REF_CLK);
        RESET <= 1'b0;
        rd(scg_pkg::OFF_SLEEP_GATE, 32'h0000_0000);
        rd(scg_pkg::OFF_RUN_GATE, 32'h0000_0000);
        rd(scg_pkg::OFF_DEEP_GATE, 32'h0000_0000);
        rd(scg_pkg::OFF_RUN_CFG, 32'h0000_0000);
        rd(scg_pkg::OFF_INT_STAT, 32'h0000_0000);
        chk10("enables after reset", 10'h000);
        $display("test reset values done");
        wr(scg_pkg::OFF_SLEEP_GATE, 32'hffff_ffff);
        rd(scg_pkg::OFF_SLEEP_GATE, 32'h5000_00ff);
        settle(1);
        chk32("read idle", 32'h0000_0000, REG_RDATA);
        wr(12'h11c, 32'hffff_ffff);
        rd(12'h11c, 32'h0000_0000);
        rd(scg_pkg::OFF_SLEEP_GATE, 32'h5000_00ff);
        $display("test register map done");
        wr(scg_pkg::OFF_RUN_GATE, 32'h0000_0003);
        wr(scg_pkg::OFF_SLEEP_GATE, 32'h4000_0081);
        set_mode(1'b1, 1'b0);
        settle(2);
        chk10("sleep no auto", 10'h003);
        set_mode(1'b1, 1'b1);
        settle(2);
        chk10("deep no auto", 10'h003);
        set_mode(1'b1, 1'b0);
        wr(scg_pkg::OFF_RUN_CFG, 32'hffff_ffff);
        rd(scg_pkg::OFF_RUN_CFG, 32'h0800_0000);
        settle(2);
        chk10("sleep auto", 10'h281);
        wr(scg_pkg::OFF_DEEP_GATE, 32'h1000_0004);
        set_mode(1'b1, 1'b1);
        settle(2);
        chk10("deep auto", 10'h104);
        set_mode(1'b1, 1'b0);
        settle(2);
        chk10("back to sleep", 10'h281);
        set_mode(1'b0, 1'b0);
        settle(2);
        chk10("back to run", 10'h003);
        set_mode(1'b1, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            pos = (i < 8) ? i : ((i == 8) ? 28 : 30);
            wr(scg_pkg::OFF_SLEEP_GATE, 32'h1 << pos);
            settle(2);
            chk10($sformatf("unit %0d alone", i), 10'h001 << i);
        end
        $display("test mode select done");
        wr(scg_pkg::OFF_SLEEP_GATE, 32'h4000_0081);
        wr(scg_pkg::OFF_INT_EN, 32'h0000_0002);
        settle(2);
        acc(10'h003, 10'h002);
        settle(1);
        chk1(1'b1);
        rd(scg_pkg::OFF_INT_STAT, 32'h0000_0002);
        wr(scg_pkg::OFF_INT_CLR, 32'h0000_0002);
        settle(1);
        chk1(1'b0);
        rd(scg_pkg::OFF_INT_STAT, 32'h0000_0000);
        acc(10'h200, 10'h000);
        acc(10'h100, 10'h100);
        settle(1);
        chk1(1'b0);
        rd(scg_pkg::OFF_INT_STAT, 32'h1000_0000);
        wr(scg_pkg::OFF_INT_EN, 32'h1000_0000);
        settle(1);
        chk1(1'b1);
        wr(scg_pkg::OFF_INT_CLR, 32'h1000_0000);
        settle(1);
        chk1(1'b0);
        $display("test faults and interrupts done");
        @(posedge REF_CLK);
        RESET <= 1'b1;
        @(posedge REF_CLK);
        RESET <= 1'b0;
        settle(1);
        chk10("enables after reset", 10'h000);
        rd(scg_pkg::OFF_SLEEP_GATE, 32'h0000_0000);
        rd(scg_pkg::OFF_RUN_CFG, 32'h0000_0000);
        $display("test second reset done");
        tally_and_finish();
    end

    initial
    begin
        #50000;
        errors++;
        $display("[ERR] watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule : sleep_mode_port_clock_gating_tb
